// [src/asr_cfg.svh]
// timing constants and pin-level defaults for the static memory controller
// How it works
// [R1] memory selected only with chip_sel_n low and chip_sel_hi high
// [R2] memory deselects itself when both byte-lane enables are high
// [R3] write happens while strobe, select and a lane enable all overlap
// [R4] write data valid 25 ns before the ending edge, held after it
// [R5] address stable 40 ns before write end, changes only after that edge
// [R6] address valid no later than the start of the write
// [R7] lane enables, strobe and select each low at least 40 ns
// [R8] strobe low time at least data setup plus write turnoff
// [R9] controller drives no data for 20 ns after strobe falls
// [R10] read data valid 55 ns after address stable
// [R11] old read data held 10 ns after address change
// [R12] data valid 25 ns after output enable, 55 ns after select
// [R13] data valid within 55 ns of select active
// [R14] lane data valid within 55 ns of lane enable low
// [R15] write strobe held high through the whole read
// [R16] memory data pins high impedance while output enable is high
// [R17] select dropping with strobe high leaves outputs high impedance
// [R18] address valid before or with select and lane enables going low
// [R19] low byte stored with lower enable low, high byte with upper
// [R20] read drives only lanes whose enable is low
// [R21] minimum delays round up to whole cycles; sample after longest access
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
`define ASR_CLK_PERIOD_NS 4
`define ASR_WRITE_DATA_SETUP_NS 25
`define ASR_WRITE_TURNOFF_TIME_NS 20
`define ASR_ADDRESS_TO_WRITE_END_NS 40
`define ASR_LANE_ENABLE_TO_WRITE_END_NS 40
`define ASR_ADDRESS_ACCESS_TIME_NS 55
`define ASR_SELECT_ACCESS_TIME_NS 55
`define ASR_LANE_ENABLE_ACCESS_NS 55
`define ASR_OUTPUT_ENABLE_ACCESS_NS 25
`define ASR_ADDRESS_CHANGE_HOLD_NS 10
`define ASR_CYC(ns) (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_TURNOFF_CYC `ASR_CYC(`ASR_WRITE_TURNOFF_TIME_NS)
`define ASR_SETUP_CYC `ASR_CYC(`ASR_WRITE_DATA_SETUP_NS)
`define ASR_WR_LOW_CYC `ASR_CYC(`ASR_ADDRESS_TO_WRITE_END_NS)
`define ASR_RD_CYC `ASR_CYC(`ASR_ADDRESS_ACCESS_TIME_NS)
`define ASR_ADDR_W 21
`define ASR_DATA_W 16
`endif

// [src/asr_pkg.sv]
// types for the static memory controller
package asr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_TURNOFF,
        ST_WR_DATA,
        ST_WR_END,
        ST_RD_WAIT,
        ST_RD_END
    } asr_state_type;
endpackage

// [src/asr_timer.sv]
// cycle down-counter used for pin timing
`timescale 1ns/1ps
module asr_timer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // control
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    // status
    output logic done_out
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_reg <= '0;
        end else if (ce_in) begin
            if (load_in) begin
                count_reg <= count_in;
            end else if (count_reg != '0) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    assign done_out = (count_reg == '0);
endmodule

// [src/asr_ctrl.sv]
// clocked controller driving an asynchronous 2M x 16 static memory
`timescale 1ns/1ps
`include "asr_cfg.svh"
module asr_ctrl #(
    parameter int AW = `ASR_ADDR_W,
    parameter int DW = `ASR_DATA_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [AW-1:0] req_addr_in,
    input wire logic [DW-1:0] req_wdata_in,
    input wire logic [1:0] req_lane_in,
    output logic req_ready_out,
    // answer
    output logic rsp_valid_out,
    output logic [DW-1:0] rsp_rdata_out,
    // memory pins
    output logic [AW-1:0] addr_out,
    output logic chip_sel_n_out,
    output logic chip_sel_hi_out,
    output logic write_strobe_n_out,
    output logic output_en_n_out,
    output logic lower_byte_en_n_out,
    output logic upper_byte_en_n_out,
    output logic [DW-1:0] data_out,
    output logic data_oe_out,
    input wire logic [DW-1:0] data_in
);
    localparam logic [7:0] TURNOFF_CYC = 8'(`ASR_TURNOFF_CYC);
    localparam logic [7:0] SETUP_CYC = 8'(`ASR_SETUP_CYC);
    localparam logic [7:0] RD_CYC = 8'(`ASR_RD_CYC);
    localparam int WR_LOW_MIN = `ASR_WR_LOW_CYC;

    asr_pkg::asr_state_type state_reg;
    logic load;
    logic [7:0] load_val;
    logic done;
    logic [DW-1:0] wdata_reg;
    logic [1:0] lane_reg;
    logic take;

    // a request is taken only once the previous ready pulse has gone
    assign take = (state_reg == asr_pkg::ST_IDLE) && req_valid_in && !req_ready_out;

    // ==========================================
    // cycle timer
    asr_timer #(.WIDTH(8)) u_timer (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .load_in(load),
        .count_in(load_val),
        .done_out(done)
    );

    // ==========================================
    // sequencing
    always_comb begin
        load = 1'b0;
        load_val = 8'h00;
        case (state_reg)
            asr_pkg::ST_IDLE: begin
                if (take) begin
                    load = 1'b1;
                    load_val = req_write_in ? TURNOFF_CYC - 8'h01 : RD_CYC;  // see [R21]
                end
            end
            asr_pkg::ST_WR_TURNOFF: begin
                if (done) begin
                    load = 1'b1;
                    load_val = SETUP_CYC - 8'h01;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= asr_pkg::ST_IDLE;
        end else if (ce_in) begin
            case (state_reg)
                asr_pkg::ST_IDLE: begin
                    if (take) begin
                        state_reg <= req_write_in ? asr_pkg::ST_WR_TURNOFF : asr_pkg::ST_RD_WAIT;
                    end
                end
                asr_pkg::ST_WR_TURNOFF: begin
                    if (done) begin
                        state_reg <= asr_pkg::ST_WR_DATA;  // see [R9]
                    end
                end
                asr_pkg::ST_WR_DATA: begin
                    if (done) begin
                        state_reg <= asr_pkg::ST_WR_END;  // see [R4] [R8]
                    end
                end
                asr_pkg::ST_WR_END: state_reg <= asr_pkg::ST_IDLE;
                asr_pkg::ST_RD_WAIT: begin
                    if (done) begin
                        state_reg <= asr_pkg::ST_RD_END;  // see [R10] [R12] [R13] [R14]
                    end
                end
                asr_pkg::ST_RD_END: state_reg <= asr_pkg::ST_IDLE;
                default: state_reg <= asr_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // address, select and lane pins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_out <= '0;
            chip_sel_n_out <= 1'b1;
            chip_sel_hi_out <= 1'b0;
            lower_byte_en_n_out <= 1'b1;
            upper_byte_en_n_out <= 1'b1;
            lane_reg <= 2'h0;
            wdata_reg <= '0;
        end else if (ce_in) begin
            if (take) begin
                addr_out <= req_addr_in;  // see [R6] [R18]
                chip_sel_n_out <= 1'b0;  // see [R1]
                chip_sel_hi_out <= 1'b1;
                lower_byte_en_n_out <= ~req_lane_in[0];  // see [R19] [R20]
                upper_byte_en_n_out <= ~req_lane_in[1];
                lane_reg <= req_lane_in;
                wdata_reg <= req_wdata_in;
            end else if (state_reg == asr_pkg::ST_WR_END || state_reg == asr_pkg::ST_RD_END) begin
                chip_sel_n_out <= 1'b1;  // see [R5] [R7]
                chip_sel_hi_out <= 1'b0;
                lower_byte_en_n_out <= 1'b1;
                upper_byte_en_n_out <= 1'b1;
            end
        end
    end

    // ==========================================
    // strobe, output enable and data pins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            write_strobe_n_out <= 1'b1;
            output_en_n_out <= 1'b1;
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else if (ce_in) begin
            case (state_reg)
                asr_pkg::ST_IDLE: begin
                    write_strobe_n_out <= !(take && req_write_in);  // see [R3] [R15]
                    output_en_n_out <= !(take && !req_write_in);
                    data_oe_out <= 1'b0;
                end
                asr_pkg::ST_WR_TURNOFF: begin
                    if (done) begin
                        data_out <= wdata_reg;
                        data_oe_out <= 1'b1;
                    end
                end
                asr_pkg::ST_WR_DATA: begin
                    if (done) begin
                        write_strobe_n_out <= 1'b1;  // see [R4]
                    end
                end
                asr_pkg::ST_WR_END: begin
                    data_oe_out <= 1'b0;  // see [R4]
                end
                asr_pkg::ST_RD_WAIT: begin
                    if (done) begin
                        output_en_n_out <= 1'b1;
                    end
                end
                asr_pkg::ST_RD_END: begin
                    output_en_n_out <= 1'b1;
                end
                default: begin
                    write_strobe_n_out <= 1'b1;
                    output_en_n_out <= 1'b1;
                    data_oe_out <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // handshake and read capture
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end else if (ce_in) begin
            req_ready_out <= (state_reg == asr_pkg::ST_WR_END || state_reg == asr_pkg::ST_RD_END);
            rsp_valid_out <= 1'b0;
            if (state_reg == asr_pkg::ST_RD_WAIT && done) begin
                rsp_valid_out <= 1'b1;  // see [R21]
                rsp_rdata_out <= data_in & {{(DW/2){lane_reg[1]}}, {(DW/2){lane_reg[0]}}};
            end
        end
    end

    // ==========================================
    // checks
    logic [7:0] wr_low_cnt_reg;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_low_cnt_reg <= 8'h00;
        end else if (ce_in) begin
            wr_low_cnt_reg <= write_strobe_n_out ? 8'h00 : wr_low_cnt_reg + 8'h01;
        end
    end

    chk_strobe_width: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R7]
        $rose(write_strobe_n_out) |-> int'($past(wr_low_cnt_reg)) + 1 >= WR_LOW_MIN)
        else $error("write strobe low too short");
    chk_no_retake: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R1]
        req_ready_out |=> chip_sel_n_out)
        else $error("request taken again after ready");
    chk_no_early_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R9]
        $fell(write_strobe_n_out) |-> !data_oe_out [*5])
        else $error("data driven during turnoff");
    chk_read_strobe_high: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R15]
        !output_en_n_out |-> write_strobe_n_out)
        else $error("strobe low during read");
    chk_addr_stable: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R5]
        !write_strobe_n_out |=> $stable(addr_out))
        else $error("address moved during write");
    chk_data_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R4]
        $rose(write_strobe_n_out) |-> data_oe_out && $stable(data_out))
        else $error("write data not held at write end");
    chk_write_selected: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R1]
        !write_strobe_n_out |-> !chip_sel_n_out && chip_sel_hi_out)
        else $error("write without select");
    chk_read_sample: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R21]
        $fell(output_en_n_out) |-> ##15 rsp_valid_out)
        else $error("read sampled at wrong time");
    chk_lane_match: assert property (@(posedge clk_in) disable iff (!resetn_in)  // see [R3]
        !write_strobe_n_out |-> !(lower_byte_en_n_out && upper_byte_en_n_out) || lane_reg == 2'h0)
        else $error("write lanes inconsistent");
endmodule

// [dv/asr_mem_model.sv]
// behavioural static memory on the far side of the controller
`timescale 1ns/1ps
module asr_mem_model (
    // memory pins
    input wire logic [20:0] addr_in,
    input wire logic chip_sel_n_in,
    input wire logic chip_sel_hi_in,
    input wire logic write_strobe_n_in,
    input wire logic output_en_n_in,
    input wire logic lower_byte_en_n_in,
    input wire logic upper_byte_en_n_in,
    // data bus
    input wire logic [15:0] bus_in,
    input wire logic ctrl_oe_in,
    output logic [15:0] drv_out,
    // protocol faults seen
    output int viol_out
);
    logic [15:0] mem [0:255];
    logic sel;
    logic wr_on;
    logic rd;
    logic [1:0] en;
    logic [1:0] lanes_q;
    logic [15:0] nxt;
    realtime t_pin;
    realtime t_dat;
    realtime t_adr;
    realtime t_wfall;
    // ==========================================
    // select and write overlap
    assign sel = !chip_sel_n_in && chip_sel_hi_in && !(lower_byte_en_n_in && upper_byte_en_n_in);
    assign wr_on = sel && !write_strobe_n_in;
    initial begin
        viol_out = 0;
        drv_out = 16'h0000;
        t_pin = 0;
        t_dat = 0;
        t_adr = 0;
        t_wfall = 0;
    end
    always @(addr_in or sel or output_en_n_in or write_strobe_n_in or lower_byte_en_n_in or upper_byte_en_n_in)
        t_pin = $realtime;
    always @(addr_in) t_adr = $realtime;
    always @(bus_in) t_dat = $realtime;
    always @(negedge write_strobe_n_in) t_wfall = $realtime;
    always @(posedge wr_on) lanes_q = {upper_byte_en_n_in, lower_byte_en_n_in};
    // ==========================================
    // write end: timing checks and store
    always @(negedge wr_on) begin
        if ($realtime - t_dat < 25 || $realtime - t_adr < 40 || $realtime - t_wfall < 40) viol_out++;
        if (!lanes_q[0]) mem[addr_in[7:0]][7:0] = bus_in[7:0];
        if (!lanes_q[1]) mem[addr_in[7:0]][15:8] = bus_in[15:8];
    end
    always @(posedge ctrl_oe_in) begin
        if (!write_strobe_n_in && $realtime - t_wfall < 20) viol_out++;
    end
    // ==========================================
    // read drive, undriven lanes toggle
    always #1 begin
        rd = sel && write_strobe_n_in && !output_en_n_in;
        en = (rd && $realtime - t_pin >= 55) ? ~{upper_byte_en_n_in, lower_byte_en_n_in} : 2'b00;
        nxt = ~drv_out;
        if ($realtime - t_pin < 10) nxt = drv_out;
        if (en[0]) nxt[7:0] = mem[addr_in[7:0]][7:0];
        if (en[1]) nxt[15:8] = mem[addr_in[7:0]][15:8];
        drv_out = nxt;
        if (ctrl_oe_in && en != 2'b00) viol_out++;
    end
endmodule

// [dv/testbench.sv]
// self-checking bench for the static memory controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ce_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic req_write_in = 1'b0;
    logic [20:0] req_addr_in = 21'h000000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic [1:0] req_lane_in = 2'h0;
    logic req_ready_out, rsp_valid_out, chip_sel_n_out, chip_sel_hi_out, write_strobe_n_out;
    logic output_en_n_out, lower_byte_en_n_out, upper_byte_en_n_out, data_oe_out;
    logic [15:0] rsp_rdata_out, data_out, data_in, mem_drv, rd;
    logic [20:0] addr_out;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int viol, lat, rlat;
    assign data_in = data_oe_out ? data_out : mem_drv;
    asr_ctrl DUT (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_lane_in(req_lane_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .addr_out(addr_out), .chip_sel_n_out(chip_sel_n_out),
        .chip_sel_hi_out(chip_sel_hi_out), .write_strobe_n_out(write_strobe_n_out),
        .output_en_n_out(output_en_n_out), .lower_byte_en_n_out(lower_byte_en_n_out),
        .upper_byte_en_n_out(upper_byte_en_n_out), .data_out(data_out), .data_oe_out(data_oe_out),
        .data_in(data_in));
    asr_mem_model mem (.addr_in(addr_out), .chip_sel_n_in(chip_sel_n_out), .chip_sel_hi_in(chip_sel_hi_out),
        .write_strobe_n_in(write_strobe_n_out), .output_en_n_in(output_en_n_out),
        .lower_byte_en_n_in(lower_byte_en_n_out), .upper_byte_en_n_in(upper_byte_en_n_out),
        .bus_in(data_in), .ctrl_oe_in(data_oe_out), .drv_out(mem_drv), .viol_out(viol));
    // ==========================================
    // clock, timeout, closing
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // one transfer, held until ready
    task automatic op(input logic w, input logic [20:0] a, input logic [15:0] d, input logic [1:0] ln);
        int n;
        n = 0;
        lat = -1;
        rlat = -1;
        rd = 16'h0000;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        req_lane_in <= ln;
        @(posedge clk_in);
        while (lat < 0 && n < 60) begin
            @(negedge clk_in);
            if (rsp_valid_out === 1'b1) begin
                rd = rsp_rdata_out;
                rlat = n;
            end
            if (req_ready_out === 1'b1) lat = n;
            n++;
        end
        @(posedge clk_in);
        req_valid_in <= 1'b0;
    endtask
    // ==========================================
    // scenarios
    task automatic t_idle();
        `CHK("sel_n", 1'b1, chip_sel_n_out)
        `CHK("sel_hi", 1'b0, chip_sel_hi_out)
        `CHK("strobe", 1'b1, write_strobe_n_out)
        `CHK("oe", 1'b1, output_en_n_out)
        `CHK("data_oe", 1'b0, data_oe_out)
        `CHK("ready", 1'b0, req_ready_out)
        `CHK("lanes", 2'b11, {upper_byte_en_n_out, lower_byte_en_n_out})
    endtask
    task automatic t_write_read();
        op(1'b1, 21'h000012, 16'ha5c3, 2'b11);
        `CHK("wr_lat", 13, lat)
        @(negedge clk_in);
        `CHK("no_retake", 1'b1, chip_sel_n_out)
        op(1'b0, 21'h000012, 16'h0000, 2'b11);
        `CHK("rd_data", 16'ha5c3, rd)
        `CHK("rd_vlat", 15, rlat)
        `CHK("rd_lat", 16, lat)
    endtask
    task automatic t_lanes();
        op(1'b1, 21'h000012, 16'h1177, 2'b01);
        op(1'b1, 21'h000012, 16'h3344, 2'b10);
        op(1'b0, 21'h000012, 16'h0000, 2'b11);
        `CHK("lane_both", 16'h3377, rd)
        op(1'b0, 21'h000012, 16'h0000, 2'b01);
        `CHK("lane_lo", 16'h0077, rd)
        op(1'b0, 21'h000012, 16'h0000, 2'b10);
        `CHK("lane_hi", 16'h3300, rd)
        op(1'b1, 21'h000012, 16'hffff, 2'b00);
        op(1'b0, 21'h000012, 16'h0000, 2'b11);
        `CHK("lane_none", 16'h3377, rd)
    endtask
    task automatic t_stall();
        fork
            op(1'b1, 21'h1fffff, 16'h5a0f, 2'b11);
            begin
                repeat (3) @(posedge clk_in);
                ce_in <= 1'b0;
                repeat (4) @(posedge clk_in);
                ce_in <= 1'b1;
            end
        join
        `CHK("stall_lat", 17, lat)
        op(1'b0, 21'h1fffff, 16'h0000, 2'b11);
        `CHK("stall_data", 16'h5a0f, rd)
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        t_idle();
        t_write_read();
        t_lanes();
        t_stall();
        `CHK("bus_faults", 0, viol)
        stop_test();
    end
endmodule
